// ---- logic/compare_and_pwm_unit.v ----
/*
  Compare and standard PWM unit with its own compare timer and PWM period
  timer, reached over a plain register port with read data one cycle late.
  Assumes ref_clk is the oscillator, sleepMode comes from the same clock
  domain, and extTimerClk is an asynchronous external timer clock.
*/
// How it works
// - Compare mode checks the 16-bit value against the 16-bit compare timer.
// - A match toggles, sets, clears or pulses the pin as the mode selects.
// - Every compare match raises the event flag; codes 0001, 1011 clear timer.
// - Clearing the control register forces the compare output latch low.
// - Internal timer holds in sleep; external timer clock keeps counting.
// - Compare works in sleep only if its timer runs; events can wake.
// - PWM mode makes a waveform with up to ten bits of duty resolution.
// - After count equals limit: clear timer, set pin unless zero, load duty.
// - A postscaler never changes the PWM period or frequency.
// - Duty writes are accepted anytime but take effect after a period match.
// - Alignment select chooses where the ten duty bits sit in the value.
// - Time base is timer plus two bits of oscillator phase or prescaler.
// - Time base equal to buffered duty drives the PWM pin low.
// - A duty beyond the period is never matched, so the pin stays high.
// - Period is (limit plus one) times four oscillator periods times prescale.
// - Limit 0xFF gives ten bits; duty ratio is value over 4(limit+1).
// - In sleep the PWM timer and unit state hold, pin keeps its level.
// - Reset returns registers to defaults and the pin to input direction.
// - Mode field decodes the compare actions, PWM as 11xx, 0000 disabled.
// - Alignment 0 takes duty 9:8 from high bits 1:0; 1 is left aligned.
`timescale 1ns/1ps
`include "compare_and_pwm_unit_regs.vh"

module compare_and_pwm_unit #(
  parameter PULSE_CYCLES = 4
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire [3:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  input  wire       regRdEn,
  output reg  [7:0] regRdData,
  input  wire       sleepMode,
  input  wire       extTimerClk,
  output wire       unitPin,
  output wire       unitPinOe,
  output wire       peripheralOut,
  output wire       unitEventFlag,
  output wire       timerMatchFlag,
  output wire       wakeRequest
);

  // Software-visible registers.
  reg  [7:0]  controlQ;
  reg  [7:0]  valueLoQ;
  reg  [7:0]  valueHiQ;
  reg  [7:0]  periodLimitQ;
  reg  [7:0]  timerCtrlQ;
  reg         eventFlagQ;
  reg         tmatchFlagQ;
  reg         dirInputQ;
  reg         wakeEnQ;
  // Timers and unit state.
  reg  [15:0] cmpCountQ;
  reg  [7:0]  pwmCountQ;
  reg  [7:0]  subCountQ;
  reg  [1:0]  phaseQ;
  reg  [9:0]  dutyBufQ;
  reg         outLatchQ;
  reg         cmpFreshQ;
  reg  [7:0]  pulseCntQ;
  reg  [2:0]  extSyncQ;

  wire        enable   = controlQ[`CTRL_ENABLE_BIT];
  wire        alignSel = controlQ[`CTRL_ALIGN_BIT];
  wire [3:0]  mode     = controlQ[`CTRL_MODE_MSB:0];
  wire [1:0]  prescSel = timerCtrlQ[`TCTL_PRESC_LSB+1:`TCTL_PRESC_LSB];
  wire        wrCtrl   = regWrEn && (regAddr == `ADDR_CONTROL);
  wire        wrStatus = regWrEn && (regAddr == `ADDR_STATUS);

  // mode decode. PWM is 11xx, compare codes are 0001, 0010 and 1000 to 1011.
  wire pwmMode  = enable && (mode[3:2] == 2'b11);
  wire cmpMode  = enable && ((mode == `MODE_TOGGLE_CLR) ||
                  (mode == `MODE_TOGGLE) || (mode == `MODE_SET) ||
                  (mode == `MODE_CLEAR) || (mode == `MODE_PULSE) ||
                  (mode == `MODE_PULSE_CLR));
  wire clrMode  = (mode == `MODE_TOGGLE_CLR) || (mode == `MODE_PULSE_CLR);

  // The external clock is caught by three flops; the edge is taken from the
  // second and third so the first stage feeds nothing else.
  wire extEdge  = extSyncQ[1] && !extSyncQ[2];
  wire extSel   = timerCtrlQ[`TCTL_CMP_EXT_BIT];

  // internal timer holds in sleep, external source keeps counting.
  wire instrTick = !sleepMode && (phaseQ == `PHASE_LAST);
  wire cmpTick   = timerCtrlQ[`TCTL_CMP_RUN_BIT] &&
                   (extSel ? extEdge : instrTick);

  wire cmpEqual  = (cmpCountQ == {valueHiQ, valueLoQ});
  // act only on the first evaluation after a count tick or a write to any register but status.
  // works in sleep as long as the selected timer still ticks.
  wire cmpHit    = cmpMode && cmpEqual && cmpFreshQ;

  // duty placement follows the alignment select.
  wire [9:0] dutyValue = alignSel ? {valueHiQ, valueLoQ[7:6]}
                                  : {valueHiQ[1:0], valueLoQ};

  // the prescaler counts oscillator cycles per timer step: four
  // times the prescale, so one timer step is four oscillator periods x N.
  // The low bits of the next time base are needed too, so that the pin
  // falls exactly when the time base reaches the duty, not one clock late.
  wire [7:0] subNext;
  reg  [7:0] subLast;
  reg  [1:0] timeBaseLow;
  reg  [1:0] nextLow;
  always @* begin
    case (prescSel)
      2'd0: begin
        subLast     = 8'h03;
        timeBaseLow = subCountQ[1:0];
        nextLow     = subNext[1:0];
      end
      2'd1: begin
        subLast     = 8'h0F;
        timeBaseLow = subCountQ[3:2];
        nextLow     = subNext[3:2];
      end
      2'd2: begin
        subLast     = 8'h3F;
        timeBaseLow = subCountQ[5:4];
        nextLow     = subNext[5:4];
      end
      default: begin
        subLast     = 8'hFF;
        timeBaseLow = subCountQ[7:6];
        nextLow     = subNext[7:6];
      end
    endcase
  end

  // only limit and prescale shape the period; no postscaler enters.
  wire pwmRun    = timerCtrlQ[`TCTL_PWM_RUN_BIT] && !sleepMode;
  wire pwmStep   = pwmRun && (subCountQ == subLast);
  assign subNext = pwmStep ? 8'h00 : subCountQ + 8'h01;
  // the step after count equals limit restarts the period.
  wire pwmRoll   = pwmStep && (pwmCountQ == periodLimitQ);
  // ten-bit time base: timer plus two low bits.
  wire [9:0] timeBase = {pwmCountQ, timeBaseLow};
  wire [7:0] nextCount = pwmStep ? pwmCountQ + 8'h01 : pwmCountQ;
  wire [9:0] nextBase  = {nextCount, nextLow};
  // equality clears; a duty past the period never matches.
  wire pwmClear  = pwmMode && pwmRun && !pwmRoll && (nextBase == dutyBufQ);

  // Instruction phase divides the oscillator by four.
  always @(posedge ref_clk) begin
    if (srst) begin
      phaseQ <= 2'h0;
    end else if (!sleepMode) begin
      phaseQ <= phaseQ + 2'h1;
    end
  end

  // External timer clock synchroniser.
  always @(posedge ref_clk) begin
    if (srst) begin
      extSyncQ <= 3'h0;
    end else begin
      extSyncQ <= {extSyncQ[1:0], extTimerClk};
    end
  end

  // all registers return to their defaults on reset.
  always @(posedge ref_clk) begin
    if (srst) begin
      controlQ     <= `CTRL_RESET;
      valueLoQ     <= 8'h00;
      valueHiQ     <= 8'h00;
      periodLimitQ <= 8'hFF;
      timerCtrlQ   <= `TCTL_RESET;
      dirInputQ    <= 1'b1;
      wakeEnQ      <= 1'b0;
    end else if (regWrEn) begin
      case (regAddr)
        // the value register takes writes at any time.
        `ADDR_CONTROL:      controlQ     <= regWrData;
        `ADDR_VALUE_LO:     valueLoQ     <= regWrData;
        `ADDR_VALUE_HI:     valueHiQ     <= regWrData;
        `ADDR_PERIOD_LIMIT: periodLimitQ <= regWrData;
        `ADDR_TIMER_CTRL:   timerCtrlQ   <= regWrData;
        `ADDR_STATUS: begin
          dirInputQ <= regWrData[`STAT_DIR_BIT];
          wakeEnQ   <= regWrData[`STAT_WAKE_EN_BIT];
        end
        default: begin
          dirInputQ <= dirInputQ;
        end
      endcase
    end
  end

  // Compare timer; software may load it, a clearing mode restarts it.
  always @(posedge ref_clk) begin
    if (srst) begin
      cmpCountQ <= 16'h0000;
    end else if (regWrEn && (regAddr == `ADDR_CMP_COUNT_LO)) begin
      cmpCountQ <= {cmpCountQ[15:8], regWrData};
    end else if (regWrEn && (regAddr == `ADDR_CMP_COUNT_HI)) begin
      cmpCountQ <= {regWrData, cmpCountQ[7:0]};
    // codes 0001 and 1011 clear the timer on a match.
    end else if (cmpHit && clrMode) begin
      cmpCountQ <= 16'h0000;
    end else if (cmpTick) begin
      cmpCountQ <= cmpCountQ + 16'h0001;
    end
  end

  // a match is armed again by a count tick or by a write to any register but status.
  always @(posedge ref_clk) begin
    if (srst) begin
      cmpFreshQ <= 1'b1;
    end else if (cmpTick || wrCtrl || (regWrEn &&
                 (regAddr != `ADDR_STATUS))) begin
      cmpFreshQ <= 1'b1;
    end else if (cmpMode) begin
      cmpFreshQ <= 1'b0;
    end
  end

  // PWM prescaler and period timer.
  always @(posedge ref_clk) begin
    if (srst) begin
      subCountQ <= 8'h00;
      pwmCountQ <= 8'h00;
    end else if (regWrEn && (regAddr == `ADDR_PWM_COUNT)) begin
      subCountQ <= 8'h00;
      pwmCountQ <= regWrData;
    end else if (pwmRun) begin
      subCountQ <= pwmStep ? 8'h00 : subCountQ + 8'h01;
      // timer clears after reaching its limit.
      if (pwmRoll) begin
        pwmCountQ <= 8'h00;
      end else if (pwmStep) begin
        pwmCountQ <= pwmCountQ + 8'h01;
      end
    end
  end

  // duty moves into its buffer only at the period restart.
  always @(posedge ref_clk) begin
    if (srst) begin
      dutyBufQ <= 10'h000;
    end else if (pwmRoll) begin
      dutyBufQ <= dutyValue;
    end
  end

  // Output latch for both compare and PWM. A pulse stays high for a fixed
  // number of oscillator cycles so slow consumers still see it.
  always @(posedge ref_clk) begin
    if (srst) begin
      outLatchQ <= 1'b0;
      pulseCntQ <= 8'h00;
    // clearing the control register, or a disabled unit, forces low.
    end else if (!enable || (mode == `MODE_OFF)) begin
      outLatchQ <= 1'b0;
      pulseCntQ <= 8'h00;
    end else if (pwmMode) begin
      pulseCntQ <= 8'h00;
      // set at the restart unless the new duty is zero, then held low.
      if (pwmRoll) begin
        outLatchQ <= (dutyValue != 10'h000);
      end else if (pwmClear) begin
        outLatchQ <= 1'b0;
      end
    end else if (pulseCntQ != 8'h00) begin
      pulseCntQ <= pulseCntQ - 8'h01;
      outLatchQ <= (pulseCntQ != 8'h01);
    // the pin action of the compare mode.
    end else if (cmpHit) begin
      case (mode)
        `MODE_TOGGLE_CLR,
        `MODE_TOGGLE:     outLatchQ <= !outLatchQ;
        `MODE_SET:        outLatchQ <= 1'b1;
        `MODE_CLEAR:      outLatchQ <= 1'b0;
        `MODE_PULSE,
        `MODE_PULSE_CLR: begin
          outLatchQ <= 1'b1;
          pulseCntQ <= PULSE_CYCLES[7:0];
        end
        default:          outLatchQ <= outLatchQ;
      endcase
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always @(posedge ref_clk) begin
    if (srst) begin
      eventFlagQ  <= 1'b0;
      tmatchFlagQ <= 1'b0;
    end else begin
      // every compare match raises the event flag; PWM at each restart.
      eventFlagQ  <= (cmpHit || (pwmMode && pwmRoll)) ||
                     (eventFlagQ &&
                      !(wrStatus && regWrData[`STAT_EVENT_BIT]));
      tmatchFlagQ <= pwmRoll ||
                     (tmatchFlagQ &&
                      !(wrStatus && regWrData[`STAT_TMATCH_BIT]));
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always @(posedge ref_clk) begin
    if (srst || !regRdEn) begin
      regRdData <= 8'h00;
    end else begin
      case (regAddr)
        `ADDR_CONTROL:      regRdData <= {controlQ[7], 1'b0, outLatchQ,
                                          controlQ[4:0]};
        `ADDR_VALUE_LO:     regRdData <= valueLoQ;
        `ADDR_VALUE_HI:     regRdData <= valueHiQ;
        `ADDR_PERIOD_LIMIT: regRdData <= periodLimitQ;
        `ADDR_TIMER_CTRL:   regRdData <= {3'h0, timerCtrlQ[4:0]};
        `ADDR_STATUS:       regRdData <= {4'h0, wakeEnQ, dirInputQ,
                                          tmatchFlagQ, eventFlagQ};
        `ADDR_PWM_COUNT:    regRdData <= pwmCountQ;
        `ADDR_CMP_COUNT_LO: regRdData <= cmpCountQ[7:0];
        `ADDR_CMP_COUNT_HI: regRdData <= cmpCountQ[15:8];
        default:            regRdData <= 8'h00;
      endcase
    end
  end

  // the pin is an input until software clears the direction bit.
  // keeping it an input hides the partial first PWM period.
  assign unitPinOe      = !dirInputQ;
  assign unitPin        = outLatchQ;
  assign peripheralOut  = outLatchQ;
  assign unitEventFlag  = eventFlagQ;
  assign timerMatchFlag = tmatchFlagQ;
  // a compare event wakes the device when enabled.
  assign wakeRequest    = eventFlagQ && wakeEnQ;

endmodule // compare_and_pwm_unit

// ---- logic/compare_and_pwm_unit_regs.vh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  compare and PWM unit. Definitions only; included by the unit, its checker and its bench.
*/
`ifndef COMPARE_AND_PWM_UNIT_REGS_VH
`define COMPARE_AND_PWM_UNIT_REGS_VH

// Register offsets on the 4-bit register address port.
`define ADDR_CONTROL       4'h0
`define ADDR_VALUE_LO      4'h1
`define ADDR_VALUE_HI      4'h2
`define ADDR_PERIOD_LIMIT  4'h3
`define ADDR_TIMER_CTRL    4'h4
`define ADDR_STATUS        4'h5
`define ADDR_PWM_COUNT     4'h6
`define ADDR_CMP_COUNT_LO  4'h7
`define ADDR_CMP_COUNT_HI  4'h8

// Control register fields.
`define CTRL_ENABLE_BIT    7
`define CTRL_OUT_BIT       5
`define CTRL_ALIGN_BIT     4
`define CTRL_MODE_MSB      3
`define CTRL_RESET         8'h00

// Timer control register fields.
`define TCTL_PWM_RUN_BIT   0
`define TCTL_PRESC_LSB     1
`define TCTL_CMP_RUN_BIT   3
`define TCTL_CMP_EXT_BIT   4
`define TCTL_RESET         8'h00

// Status register fields; flags clear by writing a one.
`define STAT_EVENT_BIT     0
`define STAT_TMATCH_BIT    1
`define STAT_DIR_BIT       2
`define STAT_WAKE_EN_BIT   3

// Mode codes.
`define MODE_OFF           4'h0
`define MODE_TOGGLE_CLR    4'h1
`define MODE_TOGGLE        4'h2
`define MODE_SET           4'h8
`define MODE_CLEAR         4'h9
`define MODE_PULSE         4'hA
`define MODE_PULSE_CLR     4'hB

// Oscillator cycles per instruction cycle, and its last phase index.
`define OSC_PER_INSTR      4
`define PHASE_LAST         2'h3

`endif

// ---- test/compare_and_pwm_unit_asserts.sv ----
/*
  Port checker for the compare and PWM unit, bound into every instance.
  Assumes one clock domain and the unit's register header.
*/
`timescale 1ns/1ps
`include "compare_and_pwm_unit_regs.vh"
module compare_and_pwm_unit_asserts (
  input logic       ref_clk,
  input logic       srst,
  input logic [3:0] regAddr,
  input logic [7:0] regWrData,
  input logic       regWrEn,
  input logic       regRdEn,
  input logic [7:0] regRdData,
  input logic       unitPin,
  input logic       unitPinOe,
  input logic       peripheralOut,
  input logic       unitEventFlag,
  input logic       timerMatchFlag,
  input logic       wakeRequest
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Status writes carry flag clears and the direction bit.
  wire stWr = regWrEn && regAddr == `ADDR_STATUS;
  sequence s_rdStat;
    regRdEn && regAddr == `ADDR_STATUS;
  endsequence
  sequence s_ctrlOff;
    regWrEn && regAddr == `ADDR_CONTROL && regWrData == 8'h00;
  endsequence

  // Read data stands for one cycle only.
  a_rd_idle: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data outside its cycle");
  a_reset_quiet: assert property (
    $fell(srst) |-> !unitPin && !unitPinOe && !unitEventFlag)
    else $error("outputs not cleared by reset");
  a_ctrl_off: assert property (s_ctrlOff |-> ##[1:2] !unitPin)
    else $error("latch not low after control clear");
  a_dir_oe: assert property (
    stWr |=> unitPinOe == !$past(regWrData[`STAT_DIR_BIT]))
    else $error("driver enable does not follow direction");
  a_oe_hold: assert property (!stWr |=> $stable(unitPinOe))
    else $error("driver enable changed without a write");
  a_event_sticky: assert property (
    unitEventFlag && !(stWr && regWrData[`STAT_EVENT_BIT]) |=> unitEventFlag)
    else $error("event flag dropped without a clear");
  a_match_sticky: assert property (
    timerMatchFlag && !(stWr && regWrData[`STAT_TMATCH_BIT])
    |=> timerMatchFlag)
    else $error("period flag dropped without a clear");
  a_wake_gate: assert property (wakeRequest |-> unitEventFlag)
    else $error("wake request without event");
  // Status readback matches the flags.
  a_rd_status: assert property (s_rdStat |=> regRdData[2:0] ==
    {!$past(unitPinOe), $past(timerMatchFlag), $past(unitEventFlag)})
    else $error("status readback wrong");
  // The peripheral copy equals the pin.
  a_out_mirror: assert property (peripheralOut == unitPin)
    else $error("peripheral output differs from pin");
endmodule // compare_and_pwm_unit_asserts

bind compare_and_pwm_unit compare_and_pwm_unit_asserts checkAll (
  .ref_clk, .srst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
  .unitPin, .unitPinOe, .peripheralOut, .unitEventFlag, .timerMatchFlag,
  .wakeRequest);

// ---- test/compare_and_pwm_unit_test.sv ----
/*
  Self-checking bench for the compare and PWM unit and a pin monitor.
  Assumes the register header and a 200 MHz ref_clk.
*/
`timescale 1ns/1ps
`include "compare_and_pwm_unit_regs.vh"
module compare_and_pwm_unit_test;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic        sleepMode = 1'b0;
  logic        extTimerClk = 1'b0;
  wire  [7:0]  regRdData;
  wire         unitPin, unitPinOe, peripheralOut;
  wire         unitEventFlag, timerMatchFlag, wakeRequest;
  wire  [15:0] highLen, periodLen;
  int          mismatches = 0;
  int          checked = 0;
  logic [7:0]  v, w;

  // Half period of 2.5 ns gives 200 MHz.
  always #2.5 ref_clk = ~ref_clk;

  compare_and_pwm_unit #(.PULSE_CYCLES(4)) dut (.ref_clk, .srst, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .sleepMode, .extTimerClk,
    .unitPin, .unitPinOe, .peripheralOut, .unitEventFlag, .timerMatchFlag,
    .wakeRequest);
  pin_monitor mon (.ref_clk, .pinIn(peripheralOut), .highLen, .periodLen);

  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus cycles: strobes launched by non-blocking assignment at an edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic waitev;
    int i = 0;
    while (unitEventFlag !== 1'b1 && i < 400) begin
      tick(1);
      i++;
    end
    chk("event flag", 16'h0001, {15'h0000, unitEventFlag});
  endtask
  task automatic hold(input logic lv, input int n);
    int bad = 0;
    repeat (n) begin
      tick(1);
      if (unitPin !== lv) bad++;
    end
    chk("pin held", 16'h0000, bad[15:0]);
  endtask

  task automatic t_reset;
    rd(`ADDR_STATUS, v);
    chk("status", 16'h0004, {8'h00, v});
    rd(`ADDR_PERIOD_LIMIT, v);
    chk("limit", 16'h00FF, {8'h00, v});
    wr(`ADDR_CONTROL, 8'h20);
    rd(`ADDR_CONTROL, v);
    chk("control", 16'h0000, {8'h00, v});
    rd(4'hF, v);
    chk("unmapped", 16'h0000, {8'h00, v});
    chk("driver", 16'h0000, {15'h0000, unitPinOe});
  endtask

  task automatic t_compare;
    logic [3:0] md [6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
    logic clr, keep;
    wr(`ADDR_VALUE_LO, 8'h03);
    wr(`ADDR_VALUE_HI, 8'h00);
    // compare timer runs synchronously on the instruction clock.
    wr(`ADDR_TIMER_CTRL, 8'h08);
    foreach (md[i]) begin
      clr = md[i] == 4'h1 || md[i] == 4'hB;
      keep = md[i] == 4'h1 || md[i] == 4'h2 || md[i] == 4'h8;
      wr(`ADDR_CONTROL, 8'h00);
      tick(2);
      chk("latch off", 16'h0000, {15'h0000, unitPin});
      wr(`ADDR_CMP_COUNT_LO, 8'h00);
      wr(`ADDR_STATUS, 8'h07);
      wr(`ADDR_CONTROL, {4'h8, md[i]});
      waitev;
      chk("pin at match", {15'h0000, md[i] != 4'h9}, {15'h0000, unitPin});
      rd(`ADDR_CMP_COUNT_LO, v);
      chk("count clear", {15'h0000, clr}, {15'h0000, v < 8'h03});
      tick(4);
      chk("pin later", {15'h0000, keep}, {15'h0000, unitPin});
    end
  endtask

  task automatic t_sleep;
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_VALUE_LO, 8'h05);
    wr(`ADDR_CMP_COUNT_LO, 8'h00);
    wr(`ADDR_STATUS, 8'h0F);
    wr(`ADDR_CONTROL, 8'h88);
    sleepMode <= 1'b1;
    rd(`ADDR_CMP_COUNT_LO, v);
    tick(20);
    rd(`ADDR_CMP_COUNT_LO, w);
    chk("held count", {8'h00, v}, {8'h00, w});
    // external clock source, never the raw oscillator.
    wr(`ADDR_TIMER_CTRL, 8'h18);
    wr(`ADDR_CMP_COUNT_LO, 8'h00);
    repeat (10) begin
      repeat (4) @(posedge ref_clk);
      extTimerClk <= ~extTimerClk;
    end
    tick(8);
    rd(`ADDR_CMP_COUNT_LO, v);
    chk("ext count", 16'h0005, {8'h00, v});
    chk("wake", 16'h0001, {15'h0000, wakeRequest});
    chk("set in sleep", 16'h0001, {15'h0000, unitPin});
    @(posedge ref_clk);
    sleepMode <= 1'b0;
    wr(`ADDR_TIMER_CTRL, 8'h00);
  endtask

  task automatic t_pwm(input logic [7:0] lim, tc, ct, hi, lo,
                       input logic [15:0] hiExp, perExp);
    wr(`ADDR_PERIOD_LIMIT, lim);
    wr(`ADDR_CONTROL, ct);
    wr(`ADDR_VALUE_HI, hi);
    wr(`ADDR_VALUE_LO, lo);
    wr(`ADDR_PWM_COUNT, 8'h00);
    // PWM timer steps every four oscillator cycles times the prescale.
    wr(`ADDR_TIMER_CTRL, tc);
    tick(3 * perExp + 8);
    chk("high time", hiExp, highLen);
    chk("period", perExp, periodLen);
  endtask

  task automatic t_pwmall;
    // driver stays off until the timer has rolled over once.
    t_pwm(8'h04, 8'h01, 8'h8C, 8'h00, 8'h08, 16'h0008, 16'h0014);
    chk("first flag", 16'h0001, {15'h0000, timerMatchFlag});
    wr(`ADDR_STATUS, 8'h03);
    tick(1);
    chk("driver on", 16'h0001, {15'h0000, unitPinOe});
    t_pwm(8'h04, 8'h01, 8'h9C, 8'h03, 8'h00, 16'h000C, 16'h0014);
    t_pwm(8'h04, 8'h03, 8'h8C, 8'h00, 8'h08, 16'h0020, 16'h0050);
    t_pwm(8'hFF, 8'h01, 8'h8C, 8'h02, 8'h00, 16'h0200, 16'h0400);
    chk("period flag", 16'h0001, {15'h0000, timerMatchFlag});
    wr(`ADDR_PERIOD_LIMIT, 8'h04);
    wr(`ADDR_VALUE_HI, 8'h00);
    wr(`ADDR_VALUE_LO, 8'h00);
    wr(`ADDR_PWM_COUNT, 8'h00);
    tick(45);
    hold(1'b0, 45);
    wr(`ADDR_VALUE_LO, 8'hFF);
    wr(`ADDR_VALUE_HI, 8'h03);
    tick(45);
    hold(1'b1, 45);
    @(posedge ref_clk);
    sleepMode <= 1'b1;
    rd(`ADDR_PWM_COUNT, v);
    tick(30);
    rd(`ADDR_PWM_COUNT, w);
    chk("pwm held", {8'h00, v}, {8'h00, w});
    hold(1'b1, 10);
    @(posedge ref_clk);
    sleepMode <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence after five reset cycles.
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_compare;
    t_sleep;
    t_pwmall;
    wrap_up;
  end

  // Watchdog: the run needs about 4000 cycles; this allows twenty times more.
  initial begin
    #400000;
    mismatches++;
    wrap_up;
  end
endmodule // compare_and_pwm_unit_test

// ---- test/pin_monitor.sv ----
/*
  Consumer model on the unit output: measures the last high time and the
  last rise-to-rise period. Assumes the output is sampled on ref_clk.
*/
`timescale 1ns/1ps
module pin_monitor (
  input  logic        ref_clk,
  input  logic        pinIn,
  output logic [15:0] highLen,
  output logic [15:0] periodLen
);
  logic [15:0] highRun = 16'h0000;
  logic [15:0] sinceRise = 16'h0000;
  logic        lastPin = 1'b0;

  initial begin
    highLen = 16'h0000;
    periodLen = 16'h0000;
  end

  // waveform measuring.
  // Counting samples, not time, so a glitch shorter than a cycle is unseen.
  always @(posedge ref_clk) begin
    if (pinIn && !lastPin) begin
      periodLen <= sinceRise;
      sinceRise <= 16'h0001;
    end else begin
      sinceRise <= sinceRise + 16'h0001;
    end
    if (!pinIn && lastPin) begin
      highLen <= highRun;
    end
    highRun <= pinIn ? highRun + 16'h0001 : 16'h0000;
    lastPin <= pinIn;
  end
endmodule // pin_monitor
